// File: common/safe_mode_selector_params.svh
// Constants for the operating-mode selector: offsets, diagnostic codes and reset values.
`ifndef SAFE_MODE_SELECTOR_PARAMS_SVH
`define SAFE_MODE_SELECTOR_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define SMS_OFF_CTRL 12'h000
`define SMS_OFF_SEL 12'h004
`define SMS_OFF_STAT 12'h008
`define SMS_OFF_DIAG 12'h00c
`define SMS_OFF_IRQ_STAT 12'h010
`define SMS_OFF_IRQ_MASK 12'h014

// Control register field positions.
`define SMS_CTRL_ENABLE_BIT 0
`define SMS_CTRL_PERMIT_BIT 1
`define SMS_CTRL_ACCEPT_BIT 2
`define SMS_CTRL_EXTREQ_BIT 3

// Reset values.
`define SMS_CTRL_RESET 32'h0000_0000
`define SMS_MASK_RESET 32'h0000_0000

// Diagnostic codes.
`define SMS_DIAG_OFF 32'h0000_0000
`define SMS_DIAG_READY 32'h0000_200a
`define SMS_DIAG_SEL_BASE 32'h0000_802a
`define SMS_DIAG_FIX_BASE 32'h0000_803a
`define SMS_DIAG_MULTI 32'h0000_f014
`define SMS_DIAG_NONE 32'h0000_f015

// Interrupt status bit positions.
`define SMS_IRQ_ACCEPT_BIT 0
`define SMS_IRQ_MULTI_BIT 1
`define SMS_IRQ_NONE_BIT 2

`endif

// File: common/safe_mode_selector_pkg.sv
// Types shared by the operating-mode selector design.
`default_nettype none
package safe_mode_selector_pkg;
  // Number of selectable operating modes.
  localparam int unsigned MODE_COUNT = 5;

  // Mode selector state, one-hot.
  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_READY = 5'b00010,
    ST_ACTIVE = 5'b00100,
    ST_MULTI_ERR = 5'b01000,
    ST_NONE_ERR = 5'b10000
  } sel_state_e;

  // Operator-side inputs gathered together.
  typedef struct packed {
    logic [MODE_COUNT-1:0] mode_select;
    logic change_permit;
    logic accept_pulse;
    logic block_enable;
  } sel_inputs_s;
endpackage
`default_nettype wire

// File: dv/mode_switch_model.sv
// Behavioural selector switch, permit key switch and accept button.
`default_nettype none
module mode_switch_model (
  input wire logic clk_i,
  input wire logic [2:0] pos_i,
  input wire logic key_i,
  input wire logic push_i,
  output logic [4:0] sel_o,
  output logic permit_o,
  output logic accept_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Contacts open at power-up so no input floats.
  initial begin
    sel_o = 5'h00;
    permit_o = 1'b0;
    accept_o = 1'b0;
  end
  // Contacts follow the operator one clock later, like slow mechanics.
  // Position 0 is between detents, 7 is two contacts made at once.
  always @(posedge clk_i) begin
    permit_o <= key_i;
    accept_o <= push_i;
    if (pos_i == 3'h7) begin
      sel_o <= 5'h03;
    end else if (pos_i == 3'h0) begin
      sel_o <= 5'h00;
    end else begin
      sel_o <= 5'h01 << (pos_i - 3'h1);
    end
  end
endmodule
`default_nettype wire

// File: dv/safe_mode_selector_assertions.sv
// Concurrent checks on the ports of the operating-mode selector.
`include "safe_mode_selector_params.svh"
`default_nettype none
module safe_mode_selector_assertions
  import safe_mode_selector_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CHANGE_PERMIT_I,
  input wire logic [MODE_COUNT-1:0] MODE_OUTPUT_O,
  input wire logic FAULT_CONTACT_O,
  input wire logic [31:0] DIAG_WORD_O,
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic BVALID_O,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic RVALID_O
);
  timeunit 1ns;
  timeprecision 100ps;
  // Low digit of the code that belongs to the mode now driven.
  wire logic [3:0] mode_nib;
  assign mode_nib = MODE_OUTPUT_O[0] ? 4'ha : MODE_OUTPUT_O[1] ? 4'hb : MODE_OUTPUT_O[2] ? 4'hc :
                    MODE_OUTPUT_O[3] ? 4'hd : 4'he;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Both write channels taken at one edge.
  sequence s_wr; AWVALID_I && AWREADY_O && WVALID_I && WREADY_O; endsequence
  // Read address taken.
  sequence s_rd; ARVALID_I && ARREADY_O; endsequence
  // Six samples let the permit's synchroniser settle before we judge.
  sequence s_locked; !CHANGE_PERMIT_I [*6]; endsequence
  property p_one; MODE_OUTPUT_O != 5'h00 |-> $onehot(MODE_OUTPUT_O); endproperty
  a_one: assert property (p_one) else $error("more than one mode output");
  property p_err; FAULT_CONTACT_O |-> MODE_OUTPUT_O == 5'h00; endproperty
  a_err: assert property (p_err) else $error("mode output during fault");
  property p_multi; DIAG_WORD_O == `SMS_DIAG_MULTI |-> FAULT_CONTACT_O; endproperty
  a_multi: assert property (p_multi) else $error("multi code without fault");
  property p_none; DIAG_WORD_O == `SMS_DIAG_NONE |-> FAULT_CONTACT_O && MODE_OUTPUT_O == 5'h00; endproperty
  a_none: assert property (p_none) else $error("none code with output or no fault");
  property p_ready; DIAG_WORD_O == `SMS_DIAG_READY |-> MODE_OUTPUT_O == 5'h00 && !FAULT_CONTACT_O; endproperty
  a_ready: assert property (p_ready) else $error("ready code with output or fault");
  property p_code;
    MODE_OUTPUT_O != 5'h00 |-> DIAG_WORD_O[31:4] inside {28'h00_0802, 28'h00_0803} && DIAG_WORD_O[3:0] == mode_nib;
  endproperty
  a_code: assert property (p_code) else $error("diag code does not match mode");
  property p_hold;
    s_locked |=> $stable(MODE_OUTPUT_O) && (MODE_OUTPUT_O == 5'h00 || DIAG_WORD_O[15:4] == 12'h803);
  endproperty
  a_hold: assert property (p_hold) else $error("mode moved or not fixed without permit");
  property p_wr; s_wr |=> BVALID_O; endproperty
  a_wr: assert property (p_wr) else $error("write response late");
  property p_rd; s_rd |=> RVALID_O; endproperty
  a_rd: assert property (p_rd) else $error("read response late");
endmodule
bind safe_mode_selector safe_mode_selector_assertions u_chk (.*);
`default_nettype wire

// File: dv/test_safe_mode_selector.sv
// Self-checking bench for the operating-mode selector.
`include "safe_mode_selector_params.svh"
`default_nettype none
module test_safe_mode_selector;
  import safe_mode_selector_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // One ordinary case: operator action and the outputs it should give.
  typedef struct {
    logic [2:0] pos;
    logic key;
    logic push;
    logic [4:0] mode;
    logic [31:0] diag;
  } row_s;
  row_s rows[11];
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, blk_en = 1'b0;
  logic [2:0] pos = 3'h0;
  logic key = 1'b0, push = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, diag, rv;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [4:0] sel, mode;
  logic permit, accept, fault, irq, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rr;
  int err_count = 0, checked = 0, cycles = 0;
  mode_switch_model u_mode_switch_model (.clk_i(clk), .pos_i(pos), .key_i(key), .push_i(push),
    .sel_o(sel), .permit_o(permit), .accept_o(accept));
  safe_mode_selector u_safe_mode_selector (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
    .MODE_SELECT_IN_I(sel), .CHANGE_PERMIT_I(permit), .ACCEPT_PULSE_I(accept), .BLOCK_ENABLE_INPUT_I(blk_en),
    .MODE_OUTPUT_O(mode), .FAULT_CONTACT_O(fault), .DIAG_WORD_O(diag), .IRQ_O(irq),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
    .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
    .RVALID_O(rvalid), .RREADY_I(rready));
  // 10 MHz clock.
  initial begin
    forever #50 clk = ~clk;
  end
  // A hang is cut short well past the few hundred cycles the run needs.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic see(input logic [4:0] m, input logic [31:0] d, input logic f);
    chk("mode", {27'h0, m}, {27'h0, mode});
    chk("diag", d, diag);
    chk("fault", {31'h0, f}, {31'h0, fault});
  endtask
  // Operator sets switch and key, waits, then optionally pulses accept.
  task automatic step(input logic [2:0] p, input logic k, input logic b);
    pos <= p;
    key <= k;
    repeat (6) @(posedge clk);
    push <= b;
    repeat (3) @(posedge clk);
    push <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // Write; each channel is released at the edge that takes it.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    // Ready first, then every mode accepted and then fixed by removing the key.
    rows[0] = '{3'h1, 1'b1, 1'b0, 5'h00, `SMS_DIAG_READY};
    for (int k = 0; k < 5; k++) begin
      rows[2*k+1] = '{3'(k+1), 1'b1, 1'b1, 5'h01 << k, `SMS_DIAG_SEL_BASE + k};
      rows[2*k+2] = '{3'(k+1), 1'b0, 1'b0, 5'h01 << k, `SMS_DIAG_FIX_BASE + k};
    end
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`SMS_OFF_CTRL, rv, rr);
    chk("ctrl reset", `SMS_CTRL_RESET, rv);
    rd(`SMS_OFF_IRQ_MASK, rv, rr);
    chk("mask reset", `SMS_MASK_RESET, rv);
    foreach (rows[i]) begin
      step(rows[i].pos, rows[i].key, rows[i].push);
      see(rows[i].mode, rows[i].diag, 1'b0);
      $display("row %0d done", i);
    end
    // Accept while the key is off must leave mode 5 fixed and report no acceptance.
    wr(`SMS_OFF_IRQ_STAT, 32'h7, rr);
    step(3'h1, 1'b0, 1'b1);
    see(5'h10, `SMS_DIAG_FIX_BASE + 4, 1'b0);
    rd(`SMS_OFF_IRQ_STAT, rv, rr);
    chk("stat ignored accept", 32'h0, rv);
    $display("accept without permit done");
    // Key back with no position: output drops, fault, event masked off.
    step(3'h0, 1'b1, 1'b0);
    see(5'h00, `SMS_DIAG_NONE, 1'b1);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(`SMS_OFF_IRQ_STAT, rv, rr);
    chk("stat", 32'h4, rv);
    wr(`SMS_OFF_IRQ_STAT, 32'h7, rr);
    wr(`SMS_OFF_IRQ_MASK, 32'h2, rr);
    $display("no selection done");
    // Two positions made: multi error raises the unmasked interrupt.
    step(3'h7, 1'b1, 1'b0);
    see(5'h00, `SMS_DIAG_MULTI, 1'b1);
    chk("irq", 32'h1, {31'h0, irq});
    rd(`SMS_OFF_IRQ_STAT, rv, rr);
    chk("stat", 32'h2, rv);
    wr(`SMS_OFF_IRQ_STAT, 32'h2, rr);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(12'h100, 32'h1, rr);
    chk("bresp", 32'h2, {30'h0, rr});
    rd(12'h100, rv, rr);
    chk("rresp", 32'h2, {30'h0, rr});
    chk("rdata", 32'h0, rv);
    $display("multi error and bus done");
    // One position, key and accept clear the multi error.
    step(3'h3, 1'b1, 1'b1);
    see(5'h04, `SMS_DIAG_SEL_BASE + 2, 1'b0);
    $display("recovery done");
    // A reset in mid-run drops everything; afterwards nothing is taken yet.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    see(5'h00, `SMS_DIAG_OFF, 1'b0);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    see(5'h00, `SMS_DIAG_READY, 1'b0);
    $display("reset done");
    // Switch between detents: software selection and the accept strobe take the mode.
    step(3'h0, 1'b1, 1'b0);
    see(5'h00, `SMS_DIAG_NONE, 1'b1);
    wr(`SMS_OFF_SEL, 32'h10, rr);
    wr(`SMS_OFF_CTRL, 32'h4, rr);
    repeat (4) @(posedge clk);
    see(5'h10, `SMS_DIAG_SEL_BASE + 4, 1'b0);
    $display("software accept done");
    // External enable demanded: the block stays off until the enable pin rises.
    wr(`SMS_OFF_CTRL, 32'h8, rr);
    repeat (4) @(posedge clk);
    see(5'h00, `SMS_DIAG_OFF, 1'b0);
    blk_en <= 1'b1;
    repeat (6) @(posedge clk);
    see(5'h00, `SMS_DIAG_READY, 1'b0);
    $display("external enable done");
    // Clock enable low freezes all state, even against a fresh accept.
    ce <= 1'b0;
    step(3'h2, 1'b1, 1'b1);
    see(5'h00, `SMS_DIAG_READY, 1'b0);
    ce <= 1'b1;
    $display("clock enable done");
    stop_test();
  end
endmodule
`default_nettype wire

// File: hdl/safe_mode_selector.sv
// Safety operating-mode selector with AXI4-Lite register access and one interrupt.
`include "safe_mode_selector_params.svh"
`default_nettype none

module safe_mode_selector
  import safe_mode_selector_pkg::*;
#(
  // One instance per selector; a chip may hold up to this many.
  parameter int unsigned INSTANCE_LIMIT = 7,
  // Set to one when the block needs the external enable input.
  parameter bit EXT_ENABLE_REQUIRED = 1'b0
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic [MODE_COUNT-1:0] MODE_SELECT_IN_I,
  input wire logic CHANGE_PERMIT_I,
  input wire logic ACCEPT_PULSE_I,
  input wire logic BLOCK_ENABLE_INPUT_I,
  output logic [MODE_COUNT-1:0] MODE_OUTPUT_O,
  output logic FAULT_CONTACT_O,
  output logic [31:0] DIAG_WORD_O,
  output logic IRQ_O,
  input wire logic [11:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [11:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I
);

  // Two-stage synchronisers for the pin inputs; the first stage feeds only the second.
  sel_inputs_s pin_meta;
  sel_inputs_s pin_sync;
  // Previous accept level, for the rising-edge detector.
  logic accept_prev;
  // Software control bits: enable, permit, accept strobe, external-enable requirement.
  logic [31:0] ctrl;
  // Software mode selection, ORed with the pins.
  logic [MODE_COUNT-1:0] sw_select;
  // Selector state and accepted mode, one-hot.
  sel_state_e state;
  sel_state_e next_state;
  logic [MODE_COUNT-1:0] mode_reg;
  logic [MODE_COUNT-1:0] next_mode;
  // Sticky event bits and their mask.
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  // Bus slave state.
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Pins cross into the clock domain through two flip-flops.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (CE_I) begin
      pin_meta <= {MODE_SELECT_IN_I, CHANGE_PERMIT_I, ACCEPT_PULSE_I, BLOCK_ENABLE_INPUT_I};
      pin_sync <= pin_meta;
    end
  end

  // Effective inputs: pins and software bits combined.
  wire [MODE_COUNT-1:0] sel_in = pin_sync.mode_select | sw_select;
  wire permit = pin_sync.change_permit | ctrl[`SMS_CTRL_PERMIT_BIT];
  wire accept_level = pin_sync.accept_pulse | ctrl[`SMS_CTRL_ACCEPT_BIT];
  wire accept_rise = accept_level & ~accept_prev;
  wire ext_required = EXT_ENABLE_REQUIRED | ctrl[`SMS_CTRL_EXTREQ_BIT];
  // Enable gating; without the requirement the block runs on its own.
  wire enabled = ext_required ? (pin_sync.block_enable | ctrl[`SMS_CTRL_ENABLE_BIT]) : 1'b1;
  // Count active selections: zero, one or several.
  wire sel_none = (sel_in == '0);
  wire sel_multi = ((sel_in & (sel_in - 5'd1)) != '0);
  wire sel_one = !sel_none && !sel_multi;

  // State transitions. From ready or active, errors are only recognised under permit, so a held mode survives a
  // switch moved while the key is off.
  always_comb begin
    next_state = state;
    next_mode = mode_reg;
    case (state)
      ST_OFF: begin
        if (enabled) begin
          next_state = ST_READY;
        end
      end
      ST_READY, ST_ACTIVE: begin
        if (permit) begin
          if (sel_multi) begin
            next_state = ST_MULTI_ERR;
            next_mode = '0;
          end else if (sel_none) begin
            next_state = ST_NONE_ERR;
            next_mode = '0;
          end else if (accept_rise) begin
            next_state = ST_ACTIVE;
            next_mode = sel_in;
          end
        end
      end
      ST_MULTI_ERR: begin
        // Acknowledge needs one selection, permit and accept edge.
        if (permit && sel_one && accept_rise) begin
          next_state = ST_ACTIVE;
          next_mode = sel_in;
        end
      end
      ST_NONE_ERR: begin
        if (sel_multi) begin
          next_state = ST_MULTI_ERR;
        end else if (sel_one) begin
          if (permit && accept_rise) begin
            next_state = ST_ACTIVE;
            next_mode = sel_in;
          end else begin
            next_state = ST_READY;
          end
        end
      end
      default: begin
        next_state = ST_OFF;
        next_mode = '0;
      end
    endcase
    if (!enabled) begin
      next_state = ST_OFF;
      next_mode = '0;
    end
  end

  // Selector registers.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= ST_OFF;
      mode_reg <= '0;
      accept_prev <= 1'b0;
    end else if (CE_I) begin
      state <= next_state;
      mode_reg <= next_mode;
      accept_prev <= accept_level;
    end
  end

  // Outputs: each mode output from a flop, never two at once.
  for (genvar g = 0; g < MODE_COUNT; g++) begin : g_mode_out
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        MODE_OUTPUT_O[g] <= 1'b0;
      end else if (CE_I) begin
        MODE_OUTPUT_O[g] <= next_mode[g] && (next_state == ST_ACTIVE);
      end
    end
  end

  // Diagnostic code chosen from the next state, so it aligns with the outputs.
  logic [31:0] next_diag;
  logic [2:0] next_index;
  always_comb begin
    next_index = 3'd0;
    for (int i = 0; i < MODE_COUNT; i++) begin
      if (next_mode[i]) begin
        next_index = 3'(i);
      end
    end
    case (next_state)
      ST_OFF: next_diag = `SMS_DIAG_OFF;
      ST_READY: next_diag = `SMS_DIAG_READY;
      ST_ACTIVE: next_diag = (permit ? `SMS_DIAG_SEL_BASE : `SMS_DIAG_FIX_BASE) + {29'h0, next_index};
      ST_MULTI_ERR: next_diag = `SMS_DIAG_MULTI;
      ST_NONE_ERR: next_diag = `SMS_DIAG_NONE;
      default: next_diag = `SMS_DIAG_OFF;
    endcase
  end

  // Diagnostic word, fault contact and interrupt flops; an accept ignored for lack of permit raises no event.
  wire [2:0] events = {next_state == ST_NONE_ERR && state != ST_NONE_ERR,
                       next_state == ST_MULTI_ERR && state != ST_MULTI_ERR,
                       next_state == ST_ACTIVE && accept_rise && permit};
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      DIAG_WORD_O <= `SMS_DIAG_OFF;
      FAULT_CONTACT_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else if (CE_I) begin
      DIAG_WORD_O <= next_diag;
      FAULT_CONTACT_O <= (next_state == ST_MULTI_ERR) || (next_state == ST_NONE_ERR);
      IRQ_O <= |(irq_stat & irq_mask);
    end
  end

  // Bus decode wires.
  wire aw_take = AWVALID_I && AWREADY_O;
  wire w_take = WVALID_I && WREADY_O;
  wire [11:0] wr_addr = aw_held ? aw_addr : AWADDR_I;
  wire [31:0] wr_data = w_held ? w_data : WDATA_I;
  wire [3:0] wr_strb = w_held ? w_strb : WSTRB_I;
  wire wr_go = (aw_held || aw_take) && (w_held || w_take) && !BVALID_O;
  wire wr_ok = (wr_addr == `SMS_OFF_CTRL) || (wr_addr == `SMS_OFF_SEL) ||
               (wr_addr == `SMS_OFF_IRQ_STAT) || (wr_addr == `SMS_OFF_IRQ_MASK);
  wire [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire rd_go = ARVALID_I && ARREADY_O;
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (ARADDR_I)
      `SMS_OFF_CTRL: rd_val = ctrl;
      `SMS_OFF_SEL: rd_val = {27'h0, sw_select};
      `SMS_OFF_STAT: rd_val = {19'h0, state, 2'b00, FAULT_CONTACT_O, MODE_OUTPUT_O};
      `SMS_OFF_DIAG: rd_val = DIAG_WORD_O;
      `SMS_OFF_IRQ_STAT: rd_val = {29'h0, irq_stat};
      `SMS_OFF_IRQ_MASK: rd_val = {29'h0, irq_mask};
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // AXI4-Lite write path: address and data taken in either order, one response.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      AWREADY_O <= 1'b0;
      WREADY_O <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      BVALID_O <= 1'b0;
      BRESP_O <= 2'b00;
    end else if (CE_I) begin
      AWREADY_O <= !aw_held && !aw_take && !BVALID_O;
      WREADY_O <= !w_held && !w_take && !BVALID_O;
      if (aw_take) begin
        aw_addr <= AWADDR_I;
      end
      if (w_take) begin
        w_data <= WDATA_I;
        w_strb <= WSTRB_I;
      end
      aw_held <= wr_go ? 1'b0 : (aw_held || aw_take);
      w_held <= wr_go ? 1'b0 : (w_held || w_take);
      if (wr_go) begin
        BVALID_O <= 1'b1;
        BRESP_O <= wr_ok ? 2'b00 : 2'b10;
      end else if (BREADY_I) begin
        BVALID_O <= 1'b0;
      end
    end
  end

  // Register writes; the accept strobe bit clears itself after one cycle.
  // Sticky status: hardware set beats a simultaneous write-one clear.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl <= `SMS_CTRL_RESET;
      sw_select <= '0;
      irq_mask <= '0;
      irq_stat <= '0;
    end else if (CE_I) begin
      ctrl[`SMS_CTRL_ACCEPT_BIT] <= 1'b0;
      if (wr_go && wr_addr == `SMS_OFF_CTRL) begin
        ctrl <= (ctrl & ~wmask) | (wr_data & wmask & 32'h0000_000f);
      end
      if (wr_go && wr_addr == `SMS_OFF_SEL) begin
        sw_select <= wr_data[MODE_COUNT-1:0];
      end
      if (wr_go && wr_addr == `SMS_OFF_IRQ_MASK) begin
        irq_mask <= wr_data[2:0];
      end
      irq_stat <= (irq_stat & ~((wr_go && wr_addr == `SMS_OFF_IRQ_STAT) ? wr_data[2:0] : 3'b000)) | events;
    end
  end

  // AXI4-Lite read path: one read at a time, data one cycle after the address.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b0;
      RDATA_O <= '0;
      RRESP_O <= 2'b00;
    end else if (CE_I) begin
      ARREADY_O <= !RVALID_O && !rd_go;
      if (rd_go) begin
        RVALID_O <= 1'b1;
        RDATA_O <= rd_val;
        RRESP_O <= rd_ok ? 2'b00 : 2'b10;
      end else if (RREADY_I) begin
        RVALID_O <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire
